/* include/pll_clock_source_config_defines.vh */
// Register map, field positions and reset values of the clock source block
`ifndef PLL_CLOCK_SOURCE_CONFIG_DEFINES_VH
`define PLL_CLOCK_SOURCE_CONFIG_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_PLL_CTRL 12'h010
`define IDX_ABP_CTRL 12'h017
`define IDX_CAL_CTRL 12'h018
`define IDX_POSTDIV 12'h1e0
`define IDX_ROUTING 12'h1e1
`define IDX_UPDATE 12'h232
`define IDX_STATUS 12'h233

// Loop control fields
`define PWR_LSB 0
`define CP_LSB 4
`define POL_BIT 7
`define PWR_NORMAL 2'h0
`define PWR_OFF 2'h1
`define CP_HIGHZ 3'h0
`define CP_NORMAL 3'h1
`define CP_PUMP_UP 3'h2
`define CP_PUMP_DOWN 3'h3

// Routing fields
`define BYPASS_BIT 0
`define SRC_SEL_BIT 1

// Reset values
`define PLL_CTRL_RESET 8'h01
`define ABP_RESET 2'h0
`define POSTDIV_RESET 3'h2
`define ROUTING_RESET 2'h0

// Post-divider codes: ratio is code plus two
`define POSTDIV_MAX_CODE 3'h4
`define POSTDIV_OFFSET 3'h2

`endif

/* hdl/pll_clock_source_config.v */
// Clock source routing, post-divider and loop setup with AXI4-Lite registers
`include "pll_clock_source_config_defines.vh"

// Operation
// - After reset the loop sits in power-down, power field reads off code.
// - Writing normal code to power field powers the loop on.
// - Post-divider selects ratios two through six.
// - Bypass clear feeds distribution from post-divider output; reset state.
// - Bypass set feeds selected source straight to distribution.
// - Source select clear picks external clock input; reset state.
// - Source select set picks internal oscillator.
// - Reset restores power, divider, bypass and source defaults.
// - Polarity bit clear is positive, set is negative.
// - With external oscillator the internal oscillator stays powered off.
// - External oscillator clock input feeds the feedback prescaler; it is held low with source select set.
// - Post-divider path always divides by at least two.
// - Two-bit field sets anti-backlash pulse width.
// - Detector compares reference and feedback counters, drives difference.
// - Polarity matters only with external oscillator.
// - Charge pump mode: high impedance, normal, pump up, pump down.
module pll_clock_source_config (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [13:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [13:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Clock sources, asynchronous to aclk
    input wire ext_clk_in,
    input wire int_osc_in,
    // Detector inputs from reference and feedback counters
    input wire ref_cnt_out,
    input wire fb_cnt_out,
    // Routing and loop outputs
    output wire dist_clk,
    output reg loop_power_on,
    output reg int_osc_power_on,
    output wire prescaler_clk,
    output reg [2:0] active_cp_mode,
    output reg [1:0] active_abp_width,
    output reg detector_up,
    output reg detector_down,
    output reg cal_start,
    output reg cal_reset
);

    // Buffer registers
    reg [7:0] buf_pll_ctrl;
    reg [1:0] buf_abp;
    reg buf_cal;
    reg [2:0] buf_postdiv;
    reg [1:0] buf_routing;
    // Active registers
    reg [7:0] act_pll_ctrl;
    reg [2:0] act_postdiv;
    reg [1:0] act_routing;
    reg act_cal;

    // Synchronisers
    reg ext_meta, ext_sync, osc_meta, osc_sync;
    reg ref_meta, ref_sync, fb_meta, fb_sync;
    reg ref_prev, fb_prev;

    // Post-divider
    reg [2:0] div_cnt;
    reg div_out;
    reg src_prev;
    reg dist_q;
    reg prescaler_q;

    // AXI write capture
    reg aw_held, w_held;
    reg [11:0] aw_idx;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire src_clk;
    wire [2:0] ratio_m1;
    wire do_write;
    wire [11:0] ar_idx;

    function [2:0] legal_code;
        input [2:0] code;
        begin
            if (code > `POSTDIV_MAX_CODE)
                legal_code = `POSTDIV_MAX_CODE;
            else
                legal_code = code;
        end
    endfunction

    function mapped;
        input [11:0] idx;
        begin
            mapped = (idx == `IDX_PLL_CTRL) || (idx == `IDX_ABP_CTRL) ||
                (idx == `IDX_CAL_CTRL) || (idx == `IDX_POSTDIV) ||
                (idx == `IDX_ROUTING) || (idx == `IDX_UPDATE) ||
                (idx == `IDX_STATUS);
        end
    endfunction

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx = s_axi_araddr[13:2];

    // Write path: address and data accepted in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[13:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_idx) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Buffer and active registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            buf_pll_ctrl <= `PLL_CTRL_RESET;
            buf_abp <= `ABP_RESET;
            buf_cal <= 1'b0;
            buf_postdiv <= `POSTDIV_RESET;
            buf_routing <= `ROUTING_RESET;
            act_pll_ctrl <= `PLL_CTRL_RESET;
            act_postdiv <= `POSTDIV_RESET;
            act_routing <= `ROUTING_RESET;
            act_cal <= 1'b0;
            active_abp_width <= `ABP_RESET;
            cal_start <= 1'b0;
            cal_reset <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            cal_reset <= 1'b0;
            if (do_write && w_strb[0]) begin
                case (aw_idx)
                    `IDX_PLL_CTRL: buf_pll_ctrl <= w_data[7:0];
                    `IDX_ABP_CTRL: buf_abp <= w_data[1:0];
                    `IDX_CAL_CTRL: buf_cal <= w_data[0];
                    `IDX_POSTDIV: buf_postdiv <= w_data[2:0];
                    `IDX_ROUTING: buf_routing <= w_data[1:0];
                    `IDX_UPDATE: begin
                        if (w_data[0]) begin
                            act_pll_ctrl <= buf_pll_ctrl;
                            act_postdiv <= legal_code(buf_postdiv);
                            act_routing <= buf_routing;
                            active_abp_width <= buf_abp;
                            act_cal <= buf_cal;
                            // Calibration runs on a committed 0 to 1 step
                            cal_start <= buf_cal && !act_cal;
                            cal_reset <= !buf_cal;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read path; update bit self-clears so reads as zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(ar_idx) ? 2'h0 : 2'h2;
            case (ar_idx)
                `IDX_PLL_CTRL: s_axi_rdata <= {24'h000000, buf_pll_ctrl};
                `IDX_ABP_CTRL: s_axi_rdata <= {30'h00000000, buf_abp};
                `IDX_CAL_CTRL: s_axi_rdata <= {31'h00000000, buf_cal};
                `IDX_POSTDIV: s_axi_rdata <= {29'h00000000, buf_postdiv};
                `IDX_ROUTING: s_axi_rdata <= {30'h00000000, buf_routing};
                `IDX_STATUS: s_axi_rdata <= {16'h0000, act_pll_ctrl,
                    1'b0, act_postdiv, act_cal, loop_power_on,
                    act_routing};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Source synchronisers
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            fb_meta <= 1'b0;
            fb_sync <= 1'b0;
            ref_prev <= 1'b0;
            fb_prev <= 1'b0;
        end else begin
            ext_meta <= ext_clk_in;
            ext_sync <= ext_meta;
            osc_meta <= int_osc_in;
            osc_sync <= osc_meta;
            ref_meta <= ref_cnt_out;
            ref_sync <= ref_meta;
            fb_meta <= fb_cnt_out;
            fb_sync <= fb_meta;
            ref_prev <= ref_sync;
            fb_prev <= fb_sync;
        end
    end

    assign src_clk = act_routing[`SRC_SEL_BIT] ?
        osc_sync : ext_sync;
    assign ratio_m1 = act_postdiv + 3'h1;
    // Both clock outputs leave from flip-flops so a mux change cannot glitch
    assign dist_clk = dist_q;
    assign prescaler_clk = prescaler_q;

    // Post-divider counts source rising edges; ratio is code plus two
    always @(posedge aclk) begin
        if (!aresetn) begin
            src_prev <= 1'b0;
            div_cnt <= 3'h0;
            div_out <= 1'b0;
            dist_q <= 1'b0;
            prescaler_q <= 1'b0;
        end else begin
            src_prev <= src_clk;
            dist_q <= act_routing[`BYPASS_BIT] ?
                src_clk : div_out;
            prescaler_q <= act_routing[`SRC_SEL_BIT] ?
                1'b0 : ext_sync;
            if (src_clk && !src_prev) begin
                if (div_cnt >= ratio_m1) begin
                    div_cnt <= 3'h0;
                    div_out <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 3'h1;
                    if ({div_cnt, 1'b0} + 4'h2 >= {1'b0, ratio_m1} + 4'h1)
                        div_out <= 1'b0;
                end
            end
        end
    end

    // Loop power, charge pump mode and detector
    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_power_on <= 1'b0;
            int_osc_power_on <= 1'b0;
            active_cp_mode <= `CP_HIGHZ;
            detector_up <= 1'b0;
            detector_down <= 1'b0;
        end else begin
            loop_power_on <=
                act_pll_ctrl[`PWR_LSB+1:`PWR_LSB] == `PWR_NORMAL;
            int_osc_power_on <= loop_power_on &&
                act_routing[`SRC_SEL_BIT];
            active_cp_mode <= loop_power_on ?
                act_pll_ctrl[`CP_LSB+2:`CP_LSB] : `CP_HIGHZ;
            detector_up <= 1'b0;
            detector_down <= 1'b0;
            if (loop_power_on) begin
                case (act_pll_ctrl[`CP_LSB+2:`CP_LSB])
                    `CP_PUMP_UP: detector_up <= 1'b1;
                    `CP_PUMP_DOWN: detector_down <= 1'b1;
                    `CP_NORMAL: begin
                        // Leading counter edge decides direction; polarity
                        // flips only for an external oscillator
                        if ((ref_sync && !ref_prev) !=
                            (fb_sync && !fb_prev)) begin
                            if ((ref_sync && !ref_prev) ^
                                (act_pll_ctrl[`POL_BIT] &&
                                !act_routing[`SRC_SEL_BIT]))
                                detector_up <= 1'b1;
                            else
                                detector_down <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule

/* test/pll_cfg_checker_assertions.sv */
// Port-level assertions for the clock source configuration block
module pll_cfg_checker (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Register bus handshakes
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Loop and calibration controls
    input logic loop_power_on,
    input logic int_osc_power_on,
    input logic [2:0] active_cp_mode,
    input logic cal_start,
    input logic cal_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence loop_near;
        $past(loop_power_on);
    endsequence
    a_boot_loop_off:
    assert property ($rose(aresetn) |-> !loop_power_on && !int_osc_power_on
        && active_cp_mode == 3'h0) else $error("loop not off after reset");
    a_osc_needs_loop:
    assert property (int_osc_power_on |-> $past(loop_power_on))
        else $error("oscillator on with loop off");
    a_pump_needs_loop:
    assert property (active_cp_mode != 3'h0 |-> loop_near)
        else $error("pump active with loop off");
    a_start_one_cycle:
    assert property (cal_start |=> !cal_start) else $error("long start");
    a_clear_one_cycle:
    assert property (cal_reset |=> !cal_reset) else $error("long clear");
    a_cal_pulses_apart:
    assert property (cal_start |-> !cal_reset) else $error("both pulses");
    a_write_answer:
    assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("no write response");
    a_busy_no_ready:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready during response");
    a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    a_read_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
endmodule
bind pll_clock_source_config pll_cfg_checker pll_cfg_checker_i (.*);

/* test/clock_source_model.sv */
// Free-running far-side clock sources and detector counter outputs
module clock_source_model (
    // Clock sources
    output logic ext_clk_in,
    output logic int_osc_in,
    // Counter outputs
    output logic ref_cnt_out,
    output logic fb_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_clk_in = 1'h0;
        int_osc_in = 1'h0;
        ref_cnt_out = 1'h0;
        fb_cnt_out = 1'h0;
    end
    // Kept far below the sampling clock so no edge is lost
    always #16 ext_clk_in = ~ext_clk_in;
    always #24 int_osc_in = ~int_osc_in;
    always #20 ref_cnt_out = ~ref_cnt_out;
    always #28 fb_cnt_out = ~fb_cnt_out;
endmodule

/* test/tb_top.sv */
// Self-checking bench for the clock source configuration block
`include "pll_clock_source_config_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, active_abp_width, r;
    logic [2:0] active_cp_mode;
    logic ext_clk_in, int_osc_in, ref_cnt_out, fb_cnt_out, dist_clk;
    logic loop_power_on, int_osc_power_on, prescaler_clk;
    logic detector_up, detector_down, cal_start, cal_reset;
    int miscompares = 0, samples_checked = 0, starts = 0, clears = 0;
    int ups = 0, downs = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        starts <= starts + int'(cal_start === 1'h1);
        clears <= clears + int'(cal_reset === 1'h1);
        ups <= ups + int'(detector_up === 1'h1);
        downs <= downs + int'(detector_down === 1'h1);
    end
    pll_clock_source_config pll_clock_source_config_i (.*);
    clock_source_model clock_source_model_i (.*);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Ready is sampled mid-cycle, where it already holds its edge value
    task automatic bus(bit rd, logic [11:0] idx, logic [31:0] d);
        bit done, ha, hw;
        done = 0;
        @(posedge aclk);
        if (rd) begin
            s_axi_araddr <= {idx, 2'h0};
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
        end else begin
            s_axi_awaddr <= {idx, 2'h0};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
        end
        for (int t = 0; t < 50 && !done; t++) begin
            @(negedge aclk);
            ha = rd ? s_axi_arready : s_axi_awready;
            hw = !rd && s_axi_wready;
            done = rd ? s_axi_rvalid : s_axi_bvalid;
            q = s_axi_rdata;
            r = rd ? s_axi_rresp : s_axi_bresp;
            @(posedge aclk);
            if (ha && rd) s_axi_arvalid <= 1'h0;
            if (ha && !rd) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (done && rd) s_axi_rready <= 1'h0;
            if (done && !rd) s_axi_bready <= 1'h0;
        end
        if (!done) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic commit;
        bus(0, `IDX_UPDATE, 32'h1);
        repeat (3) @(posedge aclk);
    endtask
    task automatic cnt(string what, bit pre, int want);
        int n;
        logic last, cur;
        n = 0;
        last = 1'h1;
        repeat (480) begin
            @(negedge aclk);
            cur = pre ? prescaler_clk : dist_clk;
            n += int'(cur === 1'h1 && last === 1'h0);
            last = cur;
        end
        chk(what, want, (n >= want - 1 && n <= want + 1) ? want : n);
    endtask
    task automatic t_defaults;
        bus(1, `IDX_PLL_CTRL, 0);
        chk("ctrl", 32'h1, q);
        bus(1, `IDX_POSTDIV, 0);
        chk("postdiv", 32'h2, q);
        bus(1, `IDX_ROUTING, 0);
        chk("routing", 32'h0, q);
        chk("loop_on", 0, loop_power_on);
        cnt("dist_div4", 0, 15);
    endtask
    task automatic t_power;
        bus(0, `IDX_PLL_CTRL, 32'h10);
        repeat (3) @(posedge aclk);
        chk("loop_held", 0, loop_power_on);
        commit();
        chk("loop_on", 1, loop_power_on);
        chk("osc_off", 0, int_osc_power_on);
        cnt("prescaler", 1, 60);
    endtask
    task automatic t_divider;
        for (int c = 0; c < 5; c++) begin
            bus(0, `IDX_POSTDIV, c);
            commit();
            cnt("dist_ratio", 0, 60 / (c + 2));
        end
        bus(0, `IDX_ROUTING, 32'h1);
        commit();
        cnt("dist_bypass", 0, 60);
    endtask
    task automatic t_internal;
        bus(0, `IDX_POSTDIV, 32'h0);
        bus(0, `IDX_ROUTING, 32'h2);
        commit();
        chk("osc_on", 1, int_osc_power_on);
        cnt("prescaler_idle", 1, 0);
        cnt("dist_osc", 0, 20);
    endtask
    task automatic t_pump;
        for (int m = 0; m < 4; m++) begin
            bus(0, `IDX_PLL_CTRL, {m[0], m[2:0], 4'h0});
            commit();
            chk("cp_mode", m, active_cp_mode);
            bus(1, `IDX_STATUS, 0);
            chk("polarity", m[0], q[15]);
        end
        chk("pump_down", 1, detector_down);
    endtask
    // Reference edges outnumber feedback edges in the model, so positive
    // polarity gives more up pulses; the internal source ignores polarity
    task automatic t_detect;
        int u, d;
        for (int k = 0; k < 3; k++) begin
            bus(0, `IDX_PLL_CTRL, k == 0 ? 32'h10 : 32'h90);
            bus(0, `IDX_ROUTING, k == 2 ? 32'h2 : 32'h0);
            commit();
            u = ups;
            d = downs;
            repeat (480) @(posedge aclk);
            chk("dir", k != 1, ups - u > downs - d);
        end
    endtask
    task automatic t_abp_cal;
        int s0, c0;
        bus(0, `IDX_ABP_CTRL, 32'h3);
        commit();
        chk("abp", 3, active_abp_width);
        s0 = starts;
        bus(0, `IDX_CAL_CTRL, 32'h1);
        commit();
        chk("cal_start", s0 + 1, starts);
        c0 = clears;
        bus(0, `IDX_CAL_CTRL, 32'h0);
        commit();
        chk("cal_clear", c0 + 1, clears);
    endtask
    task automatic t_unmapped;
        bus(0, 12'hfff, 32'hff);
        chk("wr_resp", 2, r);
        bus(1, 12'hfff, 0);
        chk("rd_resp", 2, r);
        chk("rd_data", 0, q);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_defaults();
        t_power();
        t_divider();
        t_internal();
        t_pump();
        t_detect();
        t_abp_cal();
        t_unmapped();
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_defaults();
        complete_run();
    end
endmodule
